// *** hdl/pbi_pkg.sv ***
// constants and types shared by the pin bank interrupt block
package pbi_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_B_TRIG_CFG0 = 12'h220;
	localparam logic [11:0] OFS_B_TRIG_CFG1 = 12'h224;
	localparam logic [11:0] OFS_B_ENABLE = 12'h230;
	localparam logic [11:0] OFS_B_PENDING = 12'h234;
	localparam logic [11:0] OFS_B_DEBOUNCE = 12'h238;
	localparam logic [11:0] OFS_C_TRIG_CFG0 = 12'h240;
	localparam logic [11:0] OFS_C_ENABLE = 12'h250;
	localparam logic [11:0] OFS_C_PENDING = 12'h254;
	localparam logic [11:0] OFS_C_DEBOUNCE = 12'h258;
	localparam logic [11:0] OFS_D_TRIG_CFG0 = 12'h260;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int B_LINES_DOC = 13;
	localparam int C_LINES_DOC = 8;
	localparam int MODE_W = 4;
	localparam int MODES_PER_WORD = 8;
	localparam int DEB_EXP_LSB = 4;
	localparam int DEB_EXP_W = 3;
	localparam int DEB_SRC_BIT = 0;
	localparam int DEB_W = 4;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 3;
	localparam int DIV_W = 7;

	typedef enum logic [3:0] {
		TRIG_RISE = 4'b0000,
		TRIG_FALL = 4'b0001,
		TRIG_HIGH = 4'b0010,
		TRIG_LOW = 4'b0011,
		TRIG_BOTH = 4'b0100
	} pbi_trig_type;

endpackage

// *** hdl/pbi_sample_tick.sv ***
// sampling tick generator: oscillator select and power-of-two prescaler
`timescale 1ns/1ps
`default_nettype none

module pbi_sample_tick (
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow_oscillator,
	input wire logic fast_oscillator,
	input wire logic sample_clock_source,
	input wire logic [pbi_pkg::DEB_EXP_W-1:0] sample_clock_divider_exp,
	output logic tick
);

	// ----------------------------------------------------------------
	// oscillator synchronisers, bit 0 slow, bit 1 fast
	// ----------------------------------------------------------------
	logic [1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
	logic [1:0] filt_d;
	logic [pbi_pkg::DIV_W-1:0] div_q, div_d, limit;
	logic tick_q, tick_d, edge_sel;

	always_comb begin
		// a change counts only once the last two stages agree
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
		edge_sel = sample_clock_source ? (filt_q[1] & ~prev_q[1]) :
			(filt_q[0] & ~prev_q[0]);
		limit = pbi_pkg::DIV_W'((32'd1 << sample_clock_divider_exp) - 32'd1);
		div_d = div_q;
		tick_d = 1'b0;
		if (edge_sel) begin
			if (div_q >= limit) begin
				div_d = '0;
				tick_d = 1'b1;
			end else begin
				div_d = div_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_q <= 2'h0;
			s2_q <= 2'h0;
			s3_q <= 2'h0;
			filt_q <= 2'h0;
			prev_q <= 2'h0;
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			s1_q <= {fast_oscillator, slow_oscillator};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			prev_q <= filt_q;
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule

`default_nettype wire

// *** hdl/pbi_pin_bank_irq.sv ***
// external interrupt detection for two pin banks with an apb register port
//
// Functional notes
// - Trigger code 0 is rising edge, 1 falling, 2 high level, 3 low level, 4 both edges, others none.
// - Each line has a 4-bit trigger field, eight to a word, line zero in the lowest nibble.
// - Each line has a read-write enable bit at its line number, cleared by reset.
// - Each line has a pending flag at its line number, set while a request waits, clear at reset.
// - Writing 1 to a pending bit clears it and writing 0 leaves it as it is.
// - The sampling clock is divided by two to the power of debounce bits 6 to 4.
// - The eight-line bank sits at 0x240 trigger, 0x250 enable, 0x254 pending, 0x258 debounce.
// - The first bank has thirteen lines, 0 to 12, each with enable and pending bits.
`timescale 1ns/1ps
`default_nettype none

module pbi_pin_bank_irq #(
	parameter int B_LINES = pbi_pkg::B_LINES_DOC,
	parameter int C_LINES = pbi_pkg::C_LINES_DOC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pbi_pkg::ADDR_W-1:0] paddr,
	input wire logic [pbi_pkg::DATA_W-1:0] pwdata,
	output logic [pbi_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_oscillator,
	input wire logic fast_oscillator,
	input wire logic [B_LINES-1:0] bank_b_pins,
	input wire logic [C_LINES-1:0] bank_c_pins,
	output logic irq_bank_b,
	output logic irq_bank_c,
	output logic irq
);

	localparam int N = B_LINES + C_LINES;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// bank b has two trigger words, bank c one
	generate
		if (B_LINES < 9 || B_LINES > 16) begin : g_bad_b
			$error("bank b line count must lie between 9 and 16");
		end
		if (C_LINES < 1 || C_LINES > 8) begin : g_bad_c
			$error("bank c line count must lie between 1 and 8");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// writable nibbles of trigger word w for a bank with n lines
	function automatic logic [31:0] cfg_mask(input int n, input int w);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int k = 0; k < pbi_pkg::MODES_PER_WORD; k++) begin
			if (w * pbi_pkg::MODES_PER_WORD + k < n) begin
				m[k*pbi_pkg::MODE_W +: pbi_pkg::MODE_W] = 4'hF;
			end
		end
		return m;
	endfunction

	// trigger decision between the newly sampled level and the last one
	function automatic logic trig_hit(input logic [3:0] mode, input logic now,
		input logic last);
		logic h;
		h = 1'b0;
		case (mode)
			pbi_pkg::TRIG_RISE: h = now & ~last;
			pbi_pkg::TRIG_FALL: h = ~now & last;
			pbi_pkg::TRIG_HIGH: h = now;
			pbi_pkg::TRIG_LOW: h = ~now;
			pbi_pkg::TRIG_BOTH: h = now ^ last;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	localparam logic [31:0] B_CFG0_MASK = cfg_mask(B_LINES, 0);
	localparam logic [31:0] B_CFG1_MASK = cfg_mask(B_LINES, 1);
	localparam logic [31:0] C_CFG0_MASK = cfg_mask(C_LINES, 0);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [31:0] b_cfg0_q, b_cfg0_d, b_cfg1_q, b_cfg1_d;
	logic [31:0] c_cfg0_q, c_cfg0_d, d_cfg0_q, d_cfg0_d;
	logic [B_LINES-1:0] b_en_q, b_en_d;
	logic [C_LINES-1:0] c_en_q, c_en_d;
	logic [pbi_pkg::DEB_W-1:0] b_deb_q, b_deb_d, c_deb_q, c_deb_d;
	logic [N-1:0] pend_q, pend_d;
	logic [31:0] prdata_q, prdata_d;
	logic err_q, err_d;

	// ----------------------------------------------------------------
	// pin synchronisers and samples
	// ----------------------------------------------------------------
	logic [N-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic [N-1:0] samp_q, samp_d;
	logic [N-1:0] line_tick, line_en, line_set, line_clr;
	logic [N*pbi_pkg::MODE_W-1:0] line_mode;
	logic tick_b, tick_c;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic setup, wr, hit;
	logic [31:0] rd_val;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;

	always_comb begin
		hit = 1'b1;
		rd_val = pbi_pkg::REG_RESET;
		case (paddr)
			pbi_pkg::OFS_B_TRIG_CFG0: rd_val = b_cfg0_q;
			pbi_pkg::OFS_B_TRIG_CFG1: rd_val = b_cfg1_q;
			pbi_pkg::OFS_B_ENABLE: rd_val = 32'(b_en_q);
			pbi_pkg::OFS_B_PENDING: rd_val = 32'(pend_q[B_LINES-1:0]);
			pbi_pkg::OFS_B_DEBOUNCE: rd_val = 32'(b_deb_q[3:1]) << pbi_pkg::DEB_EXP_LSB |
				32'(b_deb_q[0]);
			pbi_pkg::OFS_C_TRIG_CFG0: rd_val = c_cfg0_q;
			pbi_pkg::OFS_C_ENABLE: rd_val = 32'(c_en_q);
			pbi_pkg::OFS_C_PENDING: rd_val = 32'(pend_q[N-1:B_LINES]);
			pbi_pkg::OFS_C_DEBOUNCE: rd_val = 32'(c_deb_q[3:1]) << pbi_pkg::DEB_EXP_LSB |
				32'(c_deb_q[0]);
			pbi_pkg::OFS_D_TRIG_CFG0: rd_val = d_cfg0_q;
			default: hit = 1'b0;
		endcase
	end

	// read data and error are captured in setup, so the access phase has them at once
	always_comb begin
		prdata_d = prdata_q;
		err_d = err_q;
		if (setup) begin
			prdata_d = rd_val;
			err_d = ~hit;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_comb begin
		b_cfg0_d = b_cfg0_q;
		b_cfg1_d = b_cfg1_q;
		c_cfg0_d = c_cfg0_q;
		d_cfg0_d = d_cfg0_q;
		b_en_d = b_en_q;
		c_en_d = c_en_q;
		b_deb_d = b_deb_q;
		c_deb_d = c_deb_q;
		if (wr) begin
			case (paddr)
				pbi_pkg::OFS_B_TRIG_CFG0: b_cfg0_d = pwdata & B_CFG0_MASK;
				pbi_pkg::OFS_B_TRIG_CFG1: b_cfg1_d = pwdata & B_CFG1_MASK;
				pbi_pkg::OFS_C_TRIG_CFG0: c_cfg0_d = pwdata & C_CFG0_MASK;
				pbi_pkg::OFS_D_TRIG_CFG0: d_cfg0_d = pwdata;
				pbi_pkg::OFS_B_ENABLE: b_en_d = pwdata[B_LINES-1:0];
				pbi_pkg::OFS_C_ENABLE: c_en_d = pwdata[C_LINES-1:0];
				pbi_pkg::OFS_B_DEBOUNCE: b_deb_d = {
					pwdata[pbi_pkg::DEB_EXP_LSB +: pbi_pkg::DEB_EXP_W],
					pwdata[pbi_pkg::DEB_SRC_BIT]};
				pbi_pkg::OFS_C_DEBOUNCE: c_deb_d = {
					pwdata[pbi_pkg::DEB_EXP_LSB +: pbi_pkg::DEB_EXP_W],
					pwdata[pbi_pkg::DEB_SRC_BIT]};
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			b_cfg0_q <= pbi_pkg::REG_RESET;
			b_cfg1_q <= pbi_pkg::REG_RESET;
			c_cfg0_q <= pbi_pkg::REG_RESET;
			d_cfg0_q <= pbi_pkg::REG_RESET;
			b_en_q <= '0;
			c_en_q <= '0;
			b_deb_q <= '0;
			c_deb_q <= '0;
			prdata_q <= pbi_pkg::REG_RESET;
			err_q <= 1'b0;
		end else begin
			b_cfg0_q <= b_cfg0_d;
			b_cfg1_q <= b_cfg1_d;
			c_cfg0_q <= c_cfg0_d;
			d_cfg0_q <= d_cfg0_d;
			b_en_q <= b_en_d;
			c_en_q <= c_en_d;
			b_deb_q <= b_deb_d;
			c_deb_q <= c_deb_d;
			prdata_q <= prdata_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// sampling ticks, one per bank
	// ----------------------------------------------------------------
	pbi_sample_tick u_tick_b (
		.clk(clk),
		.nrst(nrst),
		.slow_oscillator(slow_oscillator),
		.fast_oscillator(fast_oscillator),
		.sample_clock_source(b_deb_q[0]),
		.sample_clock_divider_exp(b_deb_q[3:1]),
		.tick(tick_b)
	);

	pbi_sample_tick u_tick_c (
		.clk(clk),
		.nrst(nrst),
		.slow_oscillator(slow_oscillator),
		.fast_oscillator(fast_oscillator),
		.sample_clock_source(c_deb_q[0]),
		.sample_clock_divider_exp(c_deb_q[3:1]),
		.tick(tick_c)
	);

	// ----------------------------------------------------------------
	// per-line view: bank b in the low lines, bank c above
	// ----------------------------------------------------------------
	assign line_tick = {{C_LINES{tick_c}}, {B_LINES{tick_b}}};
	assign line_en = {c_en_q, b_en_q};
	assign line_mode = {c_cfg0_q[C_LINES*pbi_pkg::MODE_W-1:0],
		b_cfg1_q[(B_LINES-pbi_pkg::MODES_PER_WORD)*pbi_pkg::MODE_W-1:0],
		b_cfg0_q};

	// write-one-to-clear strobes from the two pending registers
	assign line_clr = {
		(wr && paddr == pbi_pkg::OFS_C_PENDING) ? pwdata[C_LINES-1:0] : {C_LINES{1'b0}},
		(wr && paddr == pbi_pkg::OFS_B_PENDING) ? pwdata[B_LINES-1:0] : {B_LINES{1'b0}}
	};

	// ----------------------------------------------------------------
	// per-line detection
	// ----------------------------------------------------------------
	// a disabled line does not latch events; level modes re-set on every tick
	// while the level holds, so a clear only sticks once the level is gone
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_line
			always_comb begin
				filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : filt_q[gi];
				samp_d[gi] = line_tick[gi] ? filt_q[gi] : samp_q[gi];
				line_set[gi] = line_tick[gi] & line_en[gi] &
					trig_hit(line_mode[gi*pbi_pkg::MODE_W +: pbi_pkg::MODE_W],
					filt_q[gi], samp_q[gi]);
				// a set in the same cycle as its clear wins
				pend_d[gi] = line_set[gi] | (pend_q[gi] & ~line_clr[gi]);
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
			samp_q <= '0;
			pend_q <= '0;
		end else begin
			s1_q <= {bank_c_pins, bank_b_pins};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			samp_q <= samp_d;
			pend_q <= pend_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign irq_bank_b = |(pend_q[B_LINES-1:0] & b_en_q);
	assign irq_bank_c = |(pend_q[N-1:B_LINES] & c_en_q);
	assign irq = irq_bank_b | irq_bank_c;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = err_q;

endmodule

`default_nettype wire

// *** testbench/pbi_pin_bank_irq_checker.sv ***
// port-level assertions for the pin bank interrupt block
`timescale 1ns/1ps
`default_nettype none
module pbi_pin_bank_irq_checker #(
	parameter int C_LINES = pbi_pkg::C_LINES_DOC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_bank_c,
	input wire logic irq_bank_b,
	input wire logic irq
);
	logic mapped;
	logic [31:0] en_c_d;
	logic [31:0] en_c_q;
	// shadow of the enable word, so masking is judged from the bus alone
	always_comb begin
		mapped = paddr inside {12'h220, 12'h224, 12'h230, 12'h234, 12'h238, 12'h240,
			12'h250, 12'h254, 12'h258, 12'h260};
		en_c_d = en_c_q;
		if (!nrst) begin
			en_c_d = 32'h0;
		end else if (psel && penable && pwrite && paddr == 12'h250) begin
			en_c_d = pwdata & ((32'h1 << C_LINES) - 32'h1);
		end
	end
	always_ff @(posedge clk) begin
		en_c_q <= en_c_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	property p_ready;
		pready;
	endproperty
	property p_irq_or;
		irq == (irq_bank_b || irq_bank_c);
	endproperty
	property p_rst_quiet;
		disable iff (1'b0) !nrst |=> !irq && !pslverr && prdata == 32'h0;
	endproperty
	property p_err_map;
		s_setup |=> pslverr == !$past(mapped);
	endproperty
	property p_unmapped_zero;
		s_setup ##0 !mapped |=> prdata == 32'h0;
	endproperty
	property p_hold;
		s_access |=> $stable(prdata) && $stable(pslverr);
	endproperty
	property p_en_off;
		s_access ##0 pwrite && paddr == 12'h250 && pwdata[7:0] == 8'h0 |=> !irq_bank_c;
	endproperty
	property p_masked;
		en_c_q == 32'h0 |-> !irq_bank_c;
	endproperty
	property p_en_read;
		s_setup ##0 !pwrite && paddr == 12'h250 |=> prdata == en_c_q;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	a_irq_or: assert property (p_irq_or) else $error("irq not or of banks");
	a_rst_quiet: assert property (p_rst_quiet) else $error("reset not quiet");
	a_err_map: assert property (p_err_map) else $error("pslverr wrong");
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("bad unmapped data");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_en_off: assert property (p_en_off) else $error("irq after disable");
	a_masked: assert property (p_masked) else $error("irq while masked");
	a_en_read: assert property (p_en_read) else $error("enable readback");
endmodule
bind pbi_pin_bank_irq pbi_pin_bank_irq_checker #(.C_LINES(C_LINES)) chk (.clk(clk),
	.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq_bank_c(irq_bank_c), .irq_bank_b(irq_bank_b), .irq(irq));
`default_nettype wire

// *** testbench/pbi_osc_model.sv ***
// free-running stand-ins for the slow and fast sampling oscillators
`timescale 1ns/1ps
`default_nettype none
module pbi_osc_model #(
	parameter real SLOW_HALF = 15625.0,
	parameter real FAST_HALF = 20.8
) (
	output logic slow_oscillator,
	output logic fast_oscillator
);
	initial begin
		slow_oscillator = 1'b0;
		fast_oscillator = 1'b0;
	end
	// real oscillators never stop, and drift against the system clock
	always #(SLOW_HALF) slow_oscillator = ~slow_oscillator;
	always #(FAST_HALF) fast_oscillator = ~fast_oscillator;
endmodule
`default_nettype wire

// *** testbench/pbi_pin_bank_irq_tb.sv ***
// self-checking bench for the pin bank interrupt block
`timescale 1ns/1ps
`default_nettype none
module pbi_pin_bank_irq_tb;
	localparam logic [11:0] BEN = pbi_pkg::OFS_B_ENABLE;
	localparam logic [11:0] BPEND = pbi_pkg::OFS_B_PENDING;
	localparam logic [11:0] BDEB = pbi_pkg::OFS_B_DEBOUNCE;
	localparam logic [11:0] CCFG = pbi_pkg::OFS_C_TRIG_CFG0;
	localparam logic [11:0] CEN = pbi_pkg::OFS_C_ENABLE;
	localparam logic [11:0] CPEND = pbi_pkg::OFS_C_PENDING;
	localparam logic [11:0] CDEB = pbi_pkg::OFS_C_DEBOUNCE;
	localparam logic [11:0] RA [11] = '{12'h220, 12'h224, 12'h230, 12'h234, 12'h238,
		12'h240, 12'h250, 12'h254, 12'h258, 12'h260, 12'h244};
	localparam logic [31:0] RM [11] = '{32'hFFFF_FFFF, 32'h000F_FFFF, 32'h0000_1FFF,
		32'h0, 32'h71, 32'hFFFF_FFFF, 32'hFF, 32'h0, 32'h71, 32'hFFFF_FFFF, 32'h0};
	localparam logic [7:0] FIRE = 8'h3F;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [12:0] bank_b_pins = 13'h0;
	logic [7:0] bank_c_pins = 8'h0;
	logic [31:0] prdata;
	logic pready, pslverr, slow_oscillator, fast_oscillator, irq_bank_b, irq_bank_c, irq;
	int n_errors = 0;
	int n_checks = 0;
	always #2.5 clk = ~clk;
	pbi_osc_model osc (.slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator));
	pbi_pin_bank_irq uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slow_oscillator(slow_oscillator),
		.fast_oscillator(fast_oscillator), .bank_b_pins(bank_b_pins),
		.bank_c_pins(bank_c_pins), .irq_bank_b(irq_bank_b), .irq_bank_c(irq_bank_c),
		.irq(irq));
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// a slave that never answers counts as a mismatch
		if (pready !== 1'b1) begin
			n_errors++;
			$display("Error %0t: no pready", $time);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, ex});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	// polls the chosen bank request, giving up after lim cycles
	task automatic wirq(input logic c, input int lim);
		int n;
		n = 0;
		while ((c ? irq_bank_c : irq_bank_b) !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic t_regs();
		for (int i = 0; i < 11; i++) begin
			rd(RA[i], 32'h0, RA[i] == 12'h244);
			wr(RA[i], 32'hFFFF_FFFF);
			rd(RA[i], RM[i], RA[i] == 12'h244);
			wr(RA[i], 32'h0);
		end
	endtask
	task automatic t_modes();
		wr(CDEB, 32'h1);
		bank_c_pins <= 8'h2A;
		repeat (60) @(posedge clk);
		wr(CCFG, 32'h0544_3210);
		wr(CEN, 32'h7F);
		repeat (60) @(posedge clk);
		wr(CPEND, 32'hFF);
		for (int k = 0; k < 8; k++) begin
			bank_c_pins[k] <= ~bank_c_pins[k];
			wirq(1'b1, 200);
			rd(CPEND, 32'(FIRE[k]) << k, 1'b0);
			wr(CEN, 32'h7F & ~(32'h1 << k));
			chk({31'h0, irq_bank_c}, 32'h0);
			wr(CEN, 32'h7F);
			chk({31'h0, irq}, 32'(FIRE[k]));
			wr(CPEND, ~(32'h1 << k));
			rd(CPEND, 32'(FIRE[k]) << k, 1'b0);
			bank_c_pins[k] <= ~bank_c_pins[k];
			repeat (60) @(posedge clk);
			wr(CPEND, 32'h1 << k);
			rd(CPEND, 32'h0, 1'b0);
		end
	endtask
	task automatic t_bank_b();
		wr(BDEB, 32'h1);
		wr(BEN, 32'h1000);
		bank_b_pins[12] <= 1'b1;
		wirq(1'b0, 200);
		rd(BPEND, 32'h1000, 1'b0);
		chk({31'h0, irq_bank_b}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(BPEND, 32'h1000);
		rd(BPEND, 32'h0, 1'b0);
		chk({31'h0, irq_bank_b}, 32'h0);
		bank_b_pins[12] <= 1'b0;
		wr(BEN, 32'h0);
	endtask
	// re-set spacing of a held high level equals one sampling tick period
	task automatic t_rate();
		logic [31:0] dv [3] = '{32'h31, 32'h71, 32'h00};
		realtime t [3];
		real p;
		real iv;
		wr(CCFG, 32'h2);
		wr(CEN, 32'h1);
		bank_c_pins <= 8'h01;
		for (int i = 0; i < 3; i++) begin
			wr(CDEB, dv[i]);
			for (int j = 0; j < 3; j++) begin
				wirq(1'b1, 20000);
				t[j] = $realtime;
				wr(CPEND, 32'h1);
			end
			p = (dv[i][0] ? 41.6 : 31250.0) * (2.0 ** dv[i][6:4]) / 5.0;
			iv = (t[2] - t[1]) / 5.0;
			chk({31'h0, iv > p - 3.0 && iv < p + 3.0}, 32'h1);
		end
		wr(CEN, 32'h0);
		bank_c_pins <= 8'h00;
		wr(CPEND, 32'hFF);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_modes();
		t_bank_b();
		t_rate();
		results();
	end
	initial begin
		#400000;
		n_errors++;
		results();
	end
endmodule
`default_nettype wire
